//--- bench/blk_host_model.sv
`default_nettype none

// Host serial master: frames commands, mode 0, 160 ns serial clock
module blk_host_model #(
    parameter int SELECT_DELAY_NS = 20000,
    parameter int WRITE_DELAY_NS  = 5000000
) (
    // Serial pins
    output logic      sck,
    output logic      cs_b,
    output logic      serial_input,
    input  wire logic serial_output,
    input  wire logic serial_output_en
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle pins: select high, clock low
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        serial_input = 1'b0;
    end

    // One framed command, opcode then address MSB first, optional byte read
    task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int abits,
                         input logic rd, output logic [7:0] rdata);
        logic [39:0] bits;
        bits = {op, addr << (32 - abits)};
        wait ($time >= SELECT_DELAY_NS);
        if (op != blk_pkg::OP_READ_LOCK) wait ($time >= WRITE_DELAY_NS);
        #3 cs_b = 1'b0;
        for (int i = 0; i < 8 + abits; i++) begin
            serial_input = bits[39 - i];
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        rdata = 8'h00;
        // Read phase samples on rises, device shifts on falls
        for (int i = 0; i < 8 && rd; i++) begin
            #80 sck = 1'b1;
            // An undriven output reads as the inverse of its last value
            rdata = {rdata[6:0], serial_output_en ? serial_output : ~serial_output};
            #80 sck = 1'b0;
        end
        #80 cs_b = 1'b1;
        serial_input = ~serial_input; // Released line shows no stale value
        #400;
    endtask
endmodule

`default_nettype wire

//--- bench/blk_lock_ctrl_asserts.sv
`default_nettype none

// Watches the lock and soft reset block from its ports only
module blk_lock_ctrl_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Inputs watched
    input wire logic cs_b,
    input wire logic protect_scheme_select,
    input wire logic status_range_protected,
    input wire logic engine_busy,
    // Outputs watched
    input wire logic serial_output_en,
    input wire logic write_blocked,
    input wire logic busy,
    input wire logic volatile_clear,
    input wire logic reset_enabled
);
    logic [11:0] recov_q;
    logic [11:0] recov_d;

    // Cycles since the last accepted soft reset, saturating
    assign recov_d = volatile_clear ? 12'h001 :
                     (recov_q != 12'h000 && recov_q != 12'hfff) ? recov_q + 12'h001 : recov_q;

    // Recovery counter register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            recov_q <= 12'h000;
        end else begin
            recov_q <= recov_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ************************************************************
    // Properties
    // ************************************************************
    property p_reset_values;
        $rose(rst_b) |-> write_blocked && !busy && !volatile_clear && !reset_enabled
                         && !serial_output_en;
    endproperty
    property p_range_path;
        !protect_scheme_select |=> write_blocked == $past(status_range_protected);
    endproperty
    property p_busy_follows;
        engine_busy |=> busy;
    endproperty
    property p_clear_pulse;
        volatile_clear |=> !volatile_clear;
    endproperty
    property p_clear_needs_enable;
        volatile_clear |-> $past(reset_enabled, 1) || $past(reset_enabled, 2);
    endproperty
    property p_clear_cancels;
        volatile_clear |-> !reset_enabled;
    endproperty
    property p_recovery;
        recov_q != 12'h000 && recov_q < 12'hea7 |-> busy && !volatile_clear;
    endproperty
    property p_recovery_end;
        recov_q == 12'hea7 && !$past(engine_busy) |-> !busy;
    endproperty
    property p_output_released;
        cs_b [*8] |=> !serial_output_en;
    endproperty

    a_reset_values: assert property (p_reset_values) else $error("bad value after reset");
    a_range_path: assert property (p_range_path) else $error("range path wrong");
    a_busy_follows: assert property (p_busy_follows) else $error("busy missing");
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long");
    a_clear_needs_enable: assert property (p_clear_needs_enable) else $error("unarmed reset");
    a_clear_cancels: assert property (p_clear_cancels) else $error("enable kept");
    a_recovery: assert property (p_recovery) else $error("recovery broken");
    a_recovery_end: assert property (p_recovery_end) else $error("busy stuck");
    a_output_released: assert property (p_output_released) else $error("output kept");

    c_reset: cover property (volatile_clear);
    c_read: cover property ($rose(serial_output_en));
    c_armed: cover property ($rose(reset_enabled));
endmodule

bind blk_lock_ctrl blk_lock_ctrl_asserts u_asserts (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .protect_scheme_select(protect_scheme_select),
    .status_range_protected(status_range_protected), .engine_busy(engine_busy),
    .serial_output_en(serial_output_en), .write_blocked(write_blocked), .busy(busy),
    .volatile_clear(volatile_clear), .reset_enabled(reset_enabled)
);

`default_nettype wire

//--- bench/blk_lock_ctrl_tb.sv
`default_nettype none

module blk_lock_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        sck, cs_b, sdi, sdo, sdo_en, write_blocked, busy, volatile_clear, reset_enabled;
    logic        fb = 1'b0, pss = 1'b1, srp = 1'b0, eb = 1'b0;
    logic [31:0] wca = 32'h00000000;
    logic [31:0] seed = 32'h00010e95;
    int          miscompares = 0, checks = 0, clr_cnt = 0;

    // ************************************************************
    // Clock, design, host
    // ************************************************************
    always #4 clk = ~clk;

    blk_lock_ctrl dut (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .serial_input(sdi),
        .serial_output(sdo), .serial_output_en(sdo_en), .four_byte_mode(fb),
        .protect_scheme_select(pss), .status_range_protected(srp), .engine_busy(eb),
        .write_check_addr(wca), .write_blocked(write_blocked), .busy(busy),
        .volatile_clear(volatile_clear), .reset_enabled(reset_enabled));

    blk_host_model #(.WRITE_DELAY_NS(40000)) host (.sck(sck), .cs_b(cs_b), .serial_input(sdi),
        .serial_output(sdo), .serial_output_en(sdo_en));

    // Counts soft reset pulses
    always @(posedge clk) if (volatile_clear === 1'b1) clr_cnt++;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] pick_addr();
        logic [31:0] r;
        r = rnd();
        return {7'h00, fb & r[24], r[23:16], r[15:0]};
    endfunction

    function automatic logic exp_wb(input logic sel, input logic lock, input logic range);
        return sel ? lock : range;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int abits);
        logic [7:0] d;
        host.frame(op, a, abits, 1'b0, d);
        @(negedge clk);
    endtask

    task automatic rd_lock(input logic [31:0] a, input logic lock);
        logic [7:0] d;
        host.frame(blk_pkg::OP_READ_LOCK, a, fb ? 32 : 24, 1'b1, d);
        @(negedge clk);
        chk(d, {7'h00, lock});
    endtask

    task automatic wb_chk(input logic [31:0] a, input logic lock);
        logic [31:0] r;
        r = rnd();
        @(negedge clk);
        wca = a;
        srp = r[0];
        repeat (3) @(negedge clk);
        chk(write_blocked, exp_wb(pss, lock, srp));
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #600000;
        miscompares++;
        report_and_stop();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] a;
        logic [31:0] r;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        a = pick_addr();
        rd_lock(a, 1'b1);
        wb_chk(a, 1'b1);
        for (int m = 0; m < 2; m++) begin
            @(negedge clk);
            fb = m[0];
            a = pick_addr();
            cmd(blk_pkg::OP_BLOCK_UNLOCK, a, fb ? 32 : 24);
            rd_lock(a, 1'b0);
            wb_chk(a, 1'b0);
            cmd(blk_pkg::OP_BLOCK_LOCK, a, fb ? 24 : 32);
            rd_lock(a, 1'b0);
            cmd(blk_pkg::OP_BLOCK_LOCK, a, fb ? 32 : 24);
            rd_lock(a, 1'b1);
        end
        cmd(blk_pkg::OP_GLOBAL_UNLOCK, 32'h0, 0);
        rd_lock(pick_addr(), 1'b0);
        cmd(blk_pkg::OP_GLOBAL_LOCK, 32'h0, 0);
        rd_lock(pick_addr(), 1'b1);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            pss = r[0];
            wb_chk(pick_addr(), 1'b1);
        end
        pss = 1'b1;
        eb = 1'b1;
        repeat (3) @(negedge clk);
        chk(busy, 1'b1);
        eb = 1'b0;
        repeat (3) @(negedge clk);
        chk(busy, 1'b0);
        a = pick_addr();
        cmd(blk_pkg::OP_GLOBAL_UNLOCK, 32'h0, 0);
        cmd(blk_pkg::OP_RESET_ENABLE, 32'h0, 0);
        chk(reset_enabled, 1'b1);
        cmd(blk_pkg::OP_GLOBAL_UNLOCK, 32'h0, 0);
        chk(reset_enabled, 1'b0);
        cmd(blk_pkg::OP_RESET, 32'h0, 0);
        chk(clr_cnt[7:0], 8'h00);
        rd_lock(a, 1'b0);
        cmd(blk_pkg::OP_RESET_ENABLE, 32'h0, 0);
        cmd(blk_pkg::OP_RESET, 32'h0, 0);
        chk(clr_cnt[7:0], 8'h01);
        chk(busy, 1'b1);
        cmd(blk_pkg::OP_GLOBAL_UNLOCK, 32'h0, 0);
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk);
        chk(busy, 1'b0);
        rd_lock(a, 1'b1);
        // Mid-run hard reset must lock the whole array again
        cmd(blk_pkg::OP_GLOBAL_UNLOCK, 32'h0, 0);
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        chk(write_blocked, 1'b1);
        rd_lock(a, 1'b1);
        report_and_stop();
    end
endmodule

`default_nettype wire

//--- design/blk_lock_ctrl.sv
`default_nettype none

// Overview of operation
// - Lock bits protect only when scheme select is 1; else range fields decide.
// - Lock bits are volatile and all set to 1 after any reset.
// - Opcode 39h plus address, closed by select rise, clears that lock bit.
// - Lock command addresses are 32 bits in four-byte mode, else 24 bits.
// - Opcode and address bits are taken on rising serial clock edges.
// - Opcode 3Dh plus address returns lock byte, MSB first, on falling edges.
// - Lock byte LSB 1 means locked, 0 means unlocked.
// - Opcode 7Eh without address sets every lock bit.
// - Opcode 98h without address clears every lock bit.
// - Accepted reset aborts operations and clears all volatile settings.
// - Reset needs 66h immediately followed by 99h.
// - Any other command after 66h cancels the reset enable.
// - Reset takes about 30 us; no command accepted meanwhile.
// - Opcode 36h plus address, closed by select rise, sets that lock bit.
// - Busy is 1 during self-timed erase or program and during reset recovery, else 0.
module blk_lock_ctrl #(
    parameter int NUM_BLOCKS  = 512,
    parameter int BLOCK_SHIFT = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Serial pins
    input  wire logic        sck,
    input  wire logic        cs_b,
    input  wire logic        serial_input,
    output logic             serial_output,
    output logic             serial_output_en,
    // Configuration
    input  wire logic        four_byte_mode,
    input  wire logic        protect_scheme_select,
    input  wire logic        status_range_protected,
    // Erase and program engine
    input  wire logic        engine_busy,
    input  wire logic [31:0] write_check_addr,
    output logic             write_blocked,
    output logic             busy,
    // Soft reset effects
    output logic             volatile_clear,
    output logic             reset_enabled
);

    localparam int IDX_W = $clog2(NUM_BLOCKS);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Block index of a byte address
    function automatic logic [IDX_W-1:0] block_of(input logic [31:0] a);
        return a[BLOCK_SHIFT +: IDX_W];
    endfunction

    // ************************************************************
    // Pin sampling
    // ************************************************************

    blk_pkg::blk_pins_type pins_raw;
    blk_pkg::blk_pins_type pins;
    logic                  sck_prev_q;
    logic                  cs_prev_q;
    wire                   sck_rise;
    wire                   sck_fall;
    wire                   cs_rise;
    wire                   selected;

    assign pins_raw.sck  = sck;
    assign pins_raw.cs_b = cs_b;
    assign pins_raw.sdi  = serial_input;

    blk_sync3 #(
        .WIDTH (3),
        .INIT  (blk_pkg::PINS_RESET_VALUE)
    ) u_sync (
        .clk       (clk),
        .rst_b     (rst_b),
        .pin_in    (pins_raw),
        .level_out (pins)
    );

    // Edge finders on filtered levels
    assign sck_rise = pins.sck & ~sck_prev_q;
    assign sck_fall = ~pins.sck & sck_prev_q;
    assign cs_rise  = pins.cs_b & ~cs_prev_q;
    assign selected = ~pins.cs_b;

    // Previous levels
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= pins.sck;
            cs_prev_q  <= pins.cs_b;
        end
    end

    // ************************************************************
    // Frame capture
    // ************************************************************

    blk_pkg::blk_frame_type frame_q;
    blk_pkg::blk_frame_type frame_d;
    logic [5:0]             addr_bits;
    logic [5:0]             addr_end;
    logic                   opcode_full;
    logic                   addr_full;
    logic                   count_open;

    // Address length follows addressing mode
    assign addr_bits   = four_byte_mode ? blk_pkg::ADDR4_BITS : blk_pkg::ADDR3_BITS;
    assign addr_end    = blk_pkg::OPCODE_BITS + addr_bits;
    assign opcode_full = frame_q.count == blk_pkg::OPCODE_BITS;
    assign addr_full   = frame_q.count == addr_end;
    assign count_open  = frame_q.count != blk_pkg::COUNT_MAX;

    // Shift opcode then address on each rising clock
    always_comb begin
        frame_d = frame_q;
        if (!selected) begin
            frame_d = '0;
        end else if (sck_rise && count_open) begin
            if (frame_q.count < blk_pkg::OPCODE_BITS) begin
                frame_d.opcode = {frame_q.opcode[6:0], pins.sdi};
            end else if (frame_q.count < addr_end) begin
                frame_d.addr = {frame_q.addr[30:0], pins.sdi};
            end
            frame_d.count = frame_q.count + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_q <= '0;
        end else begin
            frame_q <= frame_d;
        end
    end

    // ************************************************************
    // Command decode at select rise
    // ************************************************************

    logic [11:0] rst_cnt_q;
    logic        recovering;
    wire         exec;
    wire         is_lock;
    wire         is_unlock;
    wire         is_glock;
    wire         is_gunlock;
    wire         is_enable;
    wire         is_reset;
    wire         any_cmd;
    logic        reset_en_q;

    // Frames closed during recovery are dropped
    assign recovering = rst_cnt_q != 12'h000;
    assign exec       = cs_rise & ~recovering;
    assign any_cmd    = exec & (frame_q.count >= blk_pkg::OPCODE_BITS);
    assign is_lock    = exec & addr_full & (frame_q.opcode == blk_pkg::OP_BLOCK_LOCK);
    assign is_unlock  = exec & addr_full & (frame_q.opcode == blk_pkg::OP_BLOCK_UNLOCK);
    assign is_glock   = exec & opcode_full & (frame_q.opcode == blk_pkg::OP_GLOBAL_LOCK);
    assign is_gunlock = exec & opcode_full & (frame_q.opcode == blk_pkg::OP_GLOBAL_UNLOCK);
    assign is_enable  = exec & opcode_full & (frame_q.opcode == blk_pkg::OP_RESET_ENABLE);
    assign is_reset   = exec & opcode_full & (frame_q.opcode == blk_pkg::OP_RESET)
                        & reset_en_q;

    // Reset enable: set by 66h, dropped by any other command
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_en_q <= 1'b0;
        end else if (any_cmd) begin
            reset_en_q <= is_enable;
        end
    end

    // Recovery timer after an accepted reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rst_cnt_q <= 12'h000;
        end else if (is_reset) begin
            rst_cnt_q <= blk_pkg::RESET_COUNT_LOAD;
        end else if (recovering) begin
            rst_cnt_q <= rst_cnt_q - 12'h001;
        end
    end

    // ************************************************************
    // Lock bits
    // ************************************************************

    logic [NUM_BLOCKS-1:0] lock_q;
    logic [NUM_BLOCKS-1:0] lock_d;
    wire  [IDX_W-1:0]      frame_block;

    assign frame_block = block_of(frame_q.addr);

    // Soft reset first, then global, then single-block updates
    always_comb begin
        lock_d = lock_q;
        if (is_reset || is_glock) begin
            lock_d = {NUM_BLOCKS{blk_pkg::LOCK_RESET_VALUE}};
        end else if (is_gunlock) begin
            lock_d = '0;
        end else if (is_lock) begin
            lock_d[frame_block] = 1'b1;
        end else if (is_unlock) begin
            lock_d[frame_block] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lock_q <= {NUM_BLOCKS{blk_pkg::LOCK_RESET_VALUE}};
        end else begin
            lock_q <= lock_d;
        end
    end

    // ************************************************************
    // Lock byte read-out
    // ************************************************************

    logic [2:0] bit_idx_q;
    logic       sdo_q;
    logic       sdo_en_q;
    wire        read_phase;
    wire  [7:0] lock_byte;

    // Output phase starts once the full address is in
    assign read_phase = selected & ~recovering
                        & (frame_q.opcode == blk_pkg::OP_READ_LOCK)
                        & (frame_q.count >= addr_end);
    assign lock_byte  = {7'h00, lock_q[frame_block]};

    // Shift byte out MSB first on falling edges, repeating
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bit_idx_q <= 3'h0;
            sdo_q     <= 1'b0;
            sdo_en_q  <= 1'b0;
        end else if (!read_phase) begin
            bit_idx_q <= 3'h0;
            sdo_en_q  <= 1'b0;
        end else if (sck_fall) begin
            sdo_q     <= lock_byte[blk_pkg::LOCK_BYTE_MSB - bit_idx_q];
            bit_idx_q <= bit_idx_q + 3'h1;
            sdo_en_q  <= 1'b1;
        end
    end

    assign serial_output    = sdo_q;
    assign serial_output_en = sdo_en_q;

    // ************************************************************
    // Engine side outputs
    // ************************************************************

    logic blocked_q;
    logic busy_q;
    logic vclear_q;
    wire  lock_hit;

    // Lock bits only count under the individual scheme
    assign lock_hit = lock_q[block_of(write_check_addr)];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            blocked_q <= 1'b1;
            busy_q    <= 1'b0;
            vclear_q  <= 1'b0;
        end else begin
            blocked_q <= protect_scheme_select ? lock_hit : status_range_protected;
            busy_q    <= engine_busy | recovering;
            vclear_q  <= is_reset;
        end
    end

    assign write_blocked  = blocked_q;
    assign busy           = busy_q;
    assign volatile_clear = vclear_q;
    assign reset_enabled  = reset_en_q;

endmodule

`default_nettype wire

//--- design/blk_sync3.sv
`default_nettype none

// Three-stage pin synchroniser; output follows once stages two and three agree
module blk_sync3 #(
    parameter int              WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] agree;

    // Bits whose last two stages match may update
    assign agree = ~(s2_q ^ s3_q);
    assign level_out = level_q;

    // Shift chain and filtered level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_q    <= INIT;
            s2_q    <= INIT;
            s3_q    <= INIT;
            level_q <= INIT;
        end else begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= (agree & s3_q) | (~agree & level_q);
        end
    end

endmodule

`default_nettype wire

//--- include/blk_pkg.sv
`default_nettype none

package blk_pkg;

    // ************************************************************
    // Command opcodes
    // ************************************************************
    localparam logic [7:0] OP_BLOCK_LOCK    = 8'h36;
    localparam logic [7:0] OP_BLOCK_UNLOCK  = 8'h39;
    localparam logic [7:0] OP_READ_LOCK     = 8'h3d;
    localparam logic [7:0] OP_GLOBAL_LOCK   = 8'h7e;
    localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RESET         = 8'h99;

    // ************************************************************
    // Frame bit counts
    // ************************************************************
    localparam logic [5:0] OPCODE_BITS   = 6'h08;
    localparam logic [5:0] ADDR3_BITS    = 6'h18;
    localparam logic [5:0] ADDR4_BITS    = 6'h20;
    localparam logic [5:0] COUNT_MAX     = 6'h3f;
    localparam logic [2:0] LOCK_BYTE_MSB = 3'h7;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ                   = 125;
    localparam int RESET_TIME_US             = 30;
    localparam int RESET_CYCLES              = RESET_TIME_US * CLK_MHZ;
    localparam int SUPPLY_TO_SELECT_DELAY_US = 20;
    localparam int POWER_UP_WRITE_DELAY_MS   = 5;
    localparam logic [11:0] RESET_COUNT_LOAD = RESET_CYCLES[11:0];

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic       LOCK_RESET_VALUE = 1'b1;
    localparam logic [2:0] PINS_RESET_VALUE = 3'h2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic sck;
        logic cs_b;
        logic sdi;
    } blk_pins_type;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [31:0] addr;
        logic [5:0]  count;
    } blk_frame_type;

endpackage

`default_nettype wire
